// ---- design/clock_switch_regs.vh ----
// Purpose: register map, field positions and codes of the clock switch
// Assumes: included by the design files that decode registers or variants
// Notes:   one aligned 32-bit word per register on the APB side
`ifndef CLOCK_SWITCH_REGS_VH
`define CLOCK_SWITCH_REGS_VH

// ==========================================================================
// register byte offsets
`define CSW_CTRL_OFF        8'h00
`define CSW_CONFIG_OFF      8'h04
`define CSW_STATUS_OFF      8'h08

// ==========================================================================
// control register fields
`define CSW_CTRL_SEL_A      0
`define CSW_CTRL_EN_A       1
`define CSW_CTRL_SEL_B      2
`define CSW_CTRL_EN_B       3
`define CSW_CTRL_BYP_A      4
`define CSW_CTRL_BYP_B      5
`define CSW_CTRL_EN_INV     6
`define CSW_CTRL_MUX_SEL    7
`define CSW_CTRL_W          8
`define CSW_CTRL_RST        8'h00

// ==========================================================================
// configuration register fields
`define CSW_CFG_IDLE        0
`define CSW_CFG_PICK_A      1
`define CSW_CFG_PICK_B      2
`define CSW_CFG_ASYNC       3
`define CSW_CFG_VAR_LSB     4
`define CSW_CFG_VAR_MSB     7
`define CSW_CFG_W           8
`define CSW_CFG_RST         8'h00

// ==========================================================================
// status register fields
`define CSW_STAT_CUR_LSB    0
`define CSW_STAT_CUR_MSB    1
`define CSW_STAT_PH_LSB     2
`define CSW_STAT_PH_MSB     3
`define CSW_STAT_OUT        4
`define CSW_STAT_LVL_A      5
`define CSW_STAT_LVL_B      6
`define CSW_STAT_CFG_ERR    7

// ==========================================================================
// fixed configurations of the switch
`define CSW_VAR_DUAL        4'h0
`define CSW_VAR_GATE_HIGH   4'h1
`define CSW_VAR_EDGE_MUX    4'h2
`define CSW_VAR_RISE_MUX    4'h3
`define CSW_VAR_SEL_MUX     4'h4
`define CSW_VAR_ASYNC_MUX   4'h5
`define CSW_VAR_SEL_MUX_EN  4'h6
`define CSW_VAR_GATED       4'h7
`define CSW_VAR_PLAIN       4'h8

`endif

// ---- design/clock_edge_tracker.v ----
// Purpose: level copy and edge pulses of one clock input
// Assumes: the input is taken as synchronous to pclk
// Notes:   one instance per input, so each input's edges are seen alone
`timescale 1ns/1ps
`default_nettype none

module clock_edge_tracker (
  // clock and reset
  input  wire pclk,
  input  wire presetn,
  // watched clock input
  input  wire clk_in,
  // level and one-cycle edge pulses
  output reg  level_r,
  output wire rise,
  output wire fall
);

  // ========================================================================
  // registered copy; an input that stops gives no further pulses
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_r <= 1'b0;
    end else begin
      level_r <= clk_in;
    end
  end

  assign rise = clk_in & ~level_r;
  assign fall = ~clk_in & level_r;

endmodule

`default_nettype wire

// ---- design/clock_variant_ties.v ----
// Purpose: ties the switch controls for each fixed configuration
// Assumes: control and configuration fields come from registers
// Notes:   every variant reduces to the two-input switch
`timescale 1ns/1ps
`default_nettype none
`include "clock_switch_regs.vh"

module clock_variant_ties (
  // software controls
  input  wire [`CSW_CTRL_W-1:0] ctrl,
  input  wire [3:0]             variant,
  input  wire                   idle_cfg,
  input  wire                   async_style,
  // effective switch controls
  output reg                    sel_a,
  output reg                    en_a,
  output reg                    sel_b,
  output reg                    en_b,
  output reg                    byp_a,
  output reg                    byp_b,
  output reg                    idle
);

  wire msel;
  wire gate;

  assign msel = ctrl[`CSW_CTRL_MUX_SEL];
  // optional enable inversion of the gated buffers
  assign gate = ctrl[`CSW_CTRL_EN_A] ^ ctrl[`CSW_CTRL_EN_INV];

  // ========================================================================
  // one switching core, different tie-offs
  always @* begin
    sel_a = ctrl[`CSW_CTRL_SEL_A];
    en_a  = ctrl[`CSW_CTRL_EN_A];
    sel_b = ctrl[`CSW_CTRL_SEL_B];
    en_b  = ctrl[`CSW_CTRL_EN_B];
    byp_a = ctrl[`CSW_CTRL_BYP_A];
    byp_b = ctrl[`CSW_CTRL_BYP_B];
    idle  = idle_cfg;
    case (variant)
      `CSW_VAR_DUAL: begin
        idle = idle_cfg;
      end
      `CSW_VAR_GATE_HIGH: begin
        sel_a = 1'b1;
        en_a  = gate;
        sel_b = 1'b0;
        en_b  = 1'b0;
        byp_a = 1'b0;
        byp_b = 1'b0;
        idle  = 1'b1;
      end
      `CSW_VAR_EDGE_MUX, `CSW_VAR_RISE_MUX: begin
        sel_a = 1'b1;
        sel_b = 1'b1;
        en_a  = ~msel;
        en_b  = msel;
        byp_a = async_style;
        byp_b = async_style;
        idle  = (variant == `CSW_VAR_RISE_MUX);
      end
      `CSW_VAR_SEL_MUX, `CSW_VAR_ASYNC_MUX: begin
        sel_a = ~msel;
        sel_b = msel;
        en_a  = 1'b1;
        en_b  = 1'b1;
        byp_a = (variant == `CSW_VAR_ASYNC_MUX);
        byp_b = (variant == `CSW_VAR_ASYNC_MUX);
      end
      `CSW_VAR_SEL_MUX_EN: begin
        sel_a = ~msel;
        sel_b = msel;
        en_a  = gate;
        en_b  = gate;
        byp_a = 1'b0;
        byp_b = 1'b0;
        idle  = 1'b0;
      end
      `CSW_VAR_GATED, `CSW_VAR_PLAIN: begin
        sel_a = 1'b1;
        en_a  = (variant == `CSW_VAR_PLAIN) ? 1'b1 : gate;
        sel_b = 1'b0;
        en_b  = 1'b0;
        byp_a = async_style;
        byp_b = 1'b0;
        idle  = 1'b0;
      end
      default: begin
        idle = idle_cfg;
      end
    endcase
  end

endmodule

`default_nettype wire

// ---- design/glitch_free_clock_mux.v ----
// Purpose: glitch-free two-input clock switch with an APB register port
// Assumes: clock inputs are sampled on pclk, far faster than they toggle
// Notes:   output is rebuilt from samples, so it lags inputs two cycles
//
// Functional notes
// - input A passes only with select_a and enable_a High; B likewise
// - both pairs High keeps the previously valid selection
// - selecting neither input holds the output at the idle level
// - idle 0: wait old Low, hold Low until new falls, then pass
// - rising variant: wait old High, hold High until new rises
// - idle level sets startup output, switching edge and held level
// - startup pick drives its input from configuration; never both
// - bypass_edge on an input leaves it at once on select change
// - with bypass_edge_b, reselecting A does not wait for B falling
// - selects tied High: enable switching skips old falling edge
// - selects sampled on falling edge, enables on rising edge
// - idle-High gate: disable blocks next pulse, finishes Low pulse
// - idle-High gate: enable changes in Low pulse wait for High
// - select-driven mux switches glitch-free at any time
// - late select passes one extra pulse; done within three cycles
// - mux switch style picks edge-synchronised or immediate
// - gated mux: enable Low holds output Low until selected falls
// - gated buffer outputs 0 while disabled; enable may invert
// - gate style picks glitchless or immediate gating
// - plain buffer is the gated buffer always enabled
`timescale 1ns/1ps
`default_nettype none
`include "clock_switch_regs.vh"

module glitch_free_clock_mux (
  // clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // clock inputs and switched output
  input  wire        clock_in_a,
  input  wire        clock_in_b,
  output reg         clock_out
);

  // ========================================================================
  // states and source codes
  localparam [1:0] SRC_NONE = 2'h0;
  localparam [1:0] SRC_A    = 2'h1;
  localparam [1:0] SRC_B    = 2'h2;
  localparam [1:0] PH_RUN   = 2'h0;
  localparam [1:0] PH_DROP  = 2'h1;
  localparam [1:0] PH_WAIT  = 2'h2;

  reg  [`CSW_CTRL_W-1:0] ctrl_r;
  reg  [`CSW_CFG_W-1:0]  cfg_r;
  reg                    cfg_err_r;
  reg                    reinit_r;
  reg  [1:0]             cur_r;
  reg  [1:0]             cur_nxt;
  reg  [1:0]             phase_r;
  reg  [1:0]             phase_nxt;
  reg  [1:0]             sel_s_r;
  reg  [1:0]             en_s_r;
  reg                    out_nxt;
  reg  [1:0]             want;
  reg                    cur_lvl;
  reg                    cur_byp;
  reg                    cur_sel_evt;
  reg                    cur_en_evt;
  reg                    want_evt;
  reg                    want_byp;
  reg                    want_lvl;
  reg  [31:0]            rdata_nxt;
  reg                    addr_bad;

  wire [1:0]             lvl;
  wire [1:0]             rise;
  wire [1:0]             fall;
  wire [1:0]             clk_in;
  wire                   eff_sel_a;
  wire                   eff_en_a;
  wire                   eff_sel_b;
  wire                   eff_en_b;
  wire                   eff_byp_a;
  wire                   eff_byp_b;
  wire                   idle;
  wire                   req_a;
  wire                   req_b;
  wire                   en_only;
  wire                   wr_take;
  wire                   cfg_ok;
  wire [1:0]             start_src;

  assign clk_in = {clock_in_b, clock_in_a};

  // ========================================================================
  // per-input edge watchers
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_trk
      clock_edge_tracker u_trk (
        .pclk    (pclk),
        .presetn (presetn),
        .clk_in  (clk_in[gi]),
        .level_r (lvl[gi]),
        .rise    (rise[gi]),
        .fall    (fall[gi])
      );
    end
  endgenerate

  // ========================================================================
  // fixed-configuration tie-offs
  clock_variant_ties u_ties (
    .ctrl        (ctrl_r),
    .variant     (cfg_r[`CSW_CFG_VAR_MSB:`CSW_CFG_VAR_LSB]),
    .idle_cfg    (cfg_r[`CSW_CFG_IDLE]),
    .async_style (cfg_r[`CSW_CFG_ASYNC]),
    .sel_a       (eff_sel_a),
    .en_a        (eff_en_a),
    .sel_b       (eff_sel_b),
    .en_b        (eff_en_b),
    .byp_a       (eff_byp_a),
    .byp_b       (eff_byp_b),
    .idle        (idle)
  );

  // ========================================================================
  // apb access; one-cycle access phase, pready raised in setup
  assign wr_take = psel & penable & pready & pwrite;
  // both startup picks set is refused; the old configuration stays
  assign cfg_ok  = ~(pwdata[`CSW_CFG_PICK_A] & pwdata[`CSW_CFG_PICK_B]);

  always @* begin
    rdata_nxt = 32'h0000_0000;
    addr_bad  = 1'b0;
    case (paddr)
      `CSW_CTRL_OFF: begin
        rdata_nxt[`CSW_CTRL_W-1:0] = ctrl_r;
      end
      `CSW_CONFIG_OFF: begin
        rdata_nxt[`CSW_CFG_W-1:0] = cfg_r;
      end
      `CSW_STATUS_OFF: begin
        rdata_nxt[`CSW_STAT_CUR_MSB:`CSW_STAT_CUR_LSB] = cur_r;
        rdata_nxt[`CSW_STAT_PH_MSB:`CSW_STAT_PH_LSB]   = phase_r;
        rdata_nxt[`CSW_STAT_OUT]     = clock_out;
        rdata_nxt[`CSW_STAT_LVL_A]   = lvl[0];
        rdata_nxt[`CSW_STAT_LVL_B]   = lvl[1];
        rdata_nxt[`CSW_STAT_CFG_ERR] = cfg_err_r;
      end
      default: begin
        addr_bad = 1'b1;
      end
    endcase
  end

  // bus handshake and register writes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      prdata    <= 32'h0000_0000;
      ctrl_r    <= `CSW_CTRL_RST;
      cfg_r     <= `CSW_CFG_RST;
      cfg_err_r <= 1'b0;
      reinit_r  <= 1'b0;
    end else begin
      pready   <= psel & ~penable & ~pready;
      pslverr  <= psel & ~penable & ~pready & addr_bad;
      prdata   <= (psel & ~penable & ~pwrite) ? rdata_nxt : 32'h0000_0000;
      reinit_r <= 1'b0;
      if (wr_take && paddr == `CSW_CTRL_OFF) begin
        ctrl_r <= pwdata[`CSW_CTRL_W-1:0];
      end
      if (wr_take && paddr == `CSW_CONFIG_OFF) begin
        cfg_err_r <= ~cfg_ok;
        if (cfg_ok) begin
          cfg_r    <= pwdata[`CSW_CFG_W-1:0];
          reinit_r <= 1'b1;
        end
      end
    end
  end

  // ========================================================================
  // current source view and control sampling events
  always @* begin
    case (cur_r)
      SRC_A: begin
        cur_lvl     = lvl[0];
        cur_byp     = eff_byp_a;
        cur_sel_evt = fall[0];
        cur_en_evt  = rise[0];
      end
      SRC_B: begin
        cur_lvl     = lvl[1];
        cur_byp     = eff_byp_b;
        cur_sel_evt = fall[1];
        cur_en_evt  = rise[1];
      end
      default: begin
        cur_lvl     = idle;
        cur_byp     = 1'b1;
        cur_sel_evt = 1'b1;
        cur_en_evt  = 1'b1;
      end
    endcase
  end

  // selects on falling, enables on rising edge of the current clock;
  // a bypassed or absent clock lets the controls through every cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_s_r <= 2'b00;
      en_s_r  <= 2'b00;
    end else begin
      if (cur_sel_evt || cur_byp) begin
        sel_s_r <= {eff_sel_b, eff_sel_a};
      end
      if (cur_en_evt || cur_byp) begin
        en_s_r <= {eff_en_b, eff_en_a};
      end
    end
  end

  // ========================================================================
  // wanted source from sampled pairs
  assign req_a   = sel_s_r[0] & en_s_r[0];
  assign req_b   = sel_s_r[1] & en_s_r[1];
  // enable-only switching does not wait for the old clock's edge
  assign en_only = sel_s_r[0] & sel_s_r[1];

  always @* begin
    if (req_a && req_b) begin
      want = cur_r;
    end else if (req_a) begin
      want = SRC_A;
    end else if (req_b) begin
      want = SRC_B;
    end else begin
      want = SRC_NONE;
    end
  end

  // edge of the wanted clock that lets it in, by idle level
  always @* begin
    case (want)
      SRC_A: begin
        want_lvl = lvl[0];
        want_byp = eff_byp_a;
        want_evt = idle ? rise[0] : fall[0];
      end
      SRC_B: begin
        want_lvl = lvl[1];
        want_byp = eff_byp_b;
        want_evt = idle ? rise[1] : fall[1];
      end
      default: begin
        want_lvl = idle;
        want_byp = 1'b0;
        want_evt = 1'b0;
      end
    endcase
  end

  // ========================================================================
  // switching sequence
  always @* begin
    phase_nxt = phase_r;
    cur_nxt   = cur_r;
    out_nxt   = idle;
    case (phase_r)
      PH_RUN: begin
        out_nxt = (cur_r == SRC_NONE) ? idle : cur_lvl;
        if (want != cur_r) begin
          if (cur_r == SRC_NONE || cur_byp || en_only) begin
            phase_nxt = PH_WAIT;
            cur_nxt   = SRC_NONE;
            out_nxt   = idle;
          end else begin
            phase_nxt = PH_DROP;
          end
        end
      end
      PH_DROP: begin
        // old clock keeps running until it reaches the idle level
        out_nxt = cur_lvl;
        if (want == cur_r) begin
          phase_nxt = PH_RUN;
        end else if (cur_lvl == idle || cur_byp) begin
          phase_nxt = PH_WAIT;
          cur_nxt   = SRC_NONE;
          out_nxt   = idle;
        end
      end
      PH_WAIT: begin
        out_nxt = idle;
        if (want == SRC_NONE) begin
          phase_nxt = PH_RUN;
        end else if (want_evt || want_byp) begin
          phase_nxt = PH_RUN;
          cur_nxt   = want;
          // stale pre-edge level would be a one-cycle glitch
          out_nxt   = want_byp ? want_lvl : idle;
        end
      end
      default: begin
        phase_nxt = PH_RUN;
        cur_nxt   = SRC_NONE;
      end
    endcase
  end

  // startup source after reset or a configuration write
  assign start_src = cfg_r[`CSW_CFG_PICK_A] ? SRC_A :
                     cfg_r[`CSW_CFG_PICK_B] ? SRC_B : SRC_NONE;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_r   <= PH_RUN;
      cur_r     <= SRC_NONE;
      clock_out <= 1'b0;
    end else if (reinit_r) begin
      phase_r   <= PH_RUN;
      cur_r     <= start_src;
      clock_out <= idle;
    end else begin
      phase_r   <= phase_nxt;
      cur_r     <= cur_nxt;
      clock_out <= out_nxt;
    end
  end

endmodule

`default_nettype wire

// ---- bench/clock_source_model.sv ----
// Purpose: two slow clock sources feeding the switch
// Assumes: sources are stepped from pclk, half periods set by bench
// Notes:   a stopped source holds its last level, like a dead oscillator
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// clock sources
module clock_source_model (
  // clock
  input  wire       pclk,
  // half periods in pclk cycles and run flags
  input  wire [3:0] half_a,
  input  wire [3:0] half_b,
  input  wire       run_a,
  input  wire       run_b,
  // clocks to the switch
  output logic      clock_in_a,
  output logic      clock_in_b
);
  logic [3:0] cnt_a_r;
  logic [3:0] cnt_b_r;

  // start low with fresh counters
  initial begin
    clock_in_a = 1'b0;
    clock_in_b = 1'b0;
    cnt_a_r = 4'h0;
    cnt_b_r = 4'h0;
  end

  // edges just after pclk, so enable timing is always met
  always @(posedge pclk) begin
    cnt_a_r <= cnt_a_r + 4'h1;
    cnt_b_r <= cnt_b_r + 4'h1;
    if (!run_a || cnt_a_r >= half_a - 4'h1) cnt_a_r <= 4'h0;
    if (!run_b || cnt_b_r >= half_b - 4'h1) cnt_b_r <= 4'h0;
    if (run_a && cnt_a_r >= half_a - 4'h1) clock_in_a <= ~clock_in_a;
    if (run_b && cnt_b_r >= half_b - 4'h1) clock_in_b <= ~clock_in_b;
  end
endmodule
`default_nettype wire

// ---- bench/glitch_free_clock_mux_checker.sv ----
// Purpose: port-level checks of the clock switch
// Assumes: bound to the top module, control words shadowed from apb
// Notes:   steady checks start 60 cycles after a control write
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// checker
module glitch_free_clock_mux_checker (
  // clock and reset
  input wire        pclk,
  input wire        presetn,
  // apb
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // clocks
  input wire        clock_in_a,
  input wire        clock_in_b,
  input wire        clock_out
);
  logic [7:0] ctrl_r;
  logic [7:0] cfg_r;
  logic [7:0] age_r;
  wire        wr_go = psel && penable && pready && pwrite;
  wire        mapped = paddr == 8'h00 || paddr == 8'h04 || paddr == 8'h08;
  wire        settled = age_r >= 8'h3C;
  wire        pair_a = ctrl_r[1:0] == 2'h3;
  wire        pair_b = ctrl_r[3:2] == 2'h3;

  // shadow words; age restarts so switching has time to finish
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= 8'h00;
      cfg_r <= 8'h00;
      age_r <= 8'h00;
    end else begin
      age_r <= (age_r == 8'hFF) ? age_r : age_r + 8'h01;
      if (wr_go && paddr == 8'h00) begin
        ctrl_r <= pwdata[7:0];
        age_r <= 8'h00;
      end
      if (wr_go && paddr == 8'h04 && !(pwdata[1] && pwdata[2])) begin
        cfg_r <= pwdata[7:0];
        age_r <= 8'h00;
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence answer_s;
    psel && penable && pready;
  endsequence

  a_ready_zero_wait: assert property (setup_s |=> answer_s)
    else $error("no answer in the access cycle");
  a_ready_one_cycle: assert property (answer_s |=> !pready)
    else $error("pready held too long");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_unmapped_err: assert property (setup_s ##0 !mapped |=> pslverr)
    else $error("unmapped access not refused");
  a_rdata_quiet: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside an answer");
  a_dual_pass_a: assert property (
    settled && cfg_r == 8'h00 && pair_a && !pair_b
    |-> clock_out == $past(clock_in_a, 2)) else $error("input a not passed");
  a_dual_pass_b: assert property (
    settled && cfg_r == 8'h00 && pair_b && !pair_a
    |-> clock_out == $past(clock_in_b, 2)) else $error("input b not passed");
  a_idle_level: assert property (
    settled && cfg_r[7:1] == 7'h00 && !pair_a && !pair_b
    |-> clock_out == cfg_r[0]) else $error("output not at idle level");
  a_plain_pass: assert property (
    settled && cfg_r[7:4] == 4'h8 |-> clock_out == $past(clock_in_a, 2))
    else $error("plain buffer not passing");
  a_gate_off_low: assert property (
    settled && cfg_r[7:4] == 4'h7 && ctrl_r[1] == ctrl_r[6] |-> !clock_out)
    else $error("disabled gate not low");
endmodule

bind glitch_free_clock_mux glitch_free_clock_mux_checker u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .clock_in_a(clock_in_a),
  .clock_in_b(clock_in_b), .clock_out(clock_out));
`default_nettype wire

// ---- bench/glitch_free_clock_mux_tb.sv ----
// Purpose: self-checking bench of the clock switch
// Assumes: inputs run many pclk cycles per half period
// Notes:   output compared with a two-cycle-late copy of the input
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// bench
module glitch_free_clock_mux_tb;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        clock_in_a;
  logic        clock_in_b;
  logic        clock_out;
  logic [3:0]  half_a;
  logic [3:0]  half_b;
  logic        run_a;
  logic        run_b;
  logic [31:0] rdv;
  logic        erv;
  logic [31:0] m_ctrl;
  logic [31:0] m_cfg;
  logic        m_err;
  logic        watch;
  logic        last_out;
  logic [31:0] vt[$];
  int          errors;
  int          n_tests;
  int          seed;
  int          run_len;
  int          settle;

  glitch_free_clock_mux dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .clock_in_a(clock_in_a), .clock_in_b(clock_in_b),
    .clock_out(clock_out));
  clock_source_model src (.pclk(pclk), .half_a(half_a), .half_b(half_b),
    .run_a(run_a), .run_b(run_b), .clock_in_a(clock_in_a),
    .clock_in_b(clock_in_b));

  // 125 MHz
  always #4 pclk = ~pclk;

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic give_up;
    chk("wait", 32'h1, 32'h0);
    print_verdict();
  endtask

  // one apb transfer, request held until pready is sampled
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 20) give_up();
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // access plus register model update and response check
  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    logic [31:0] e;
    e = (!w && a == 8'h00) ? m_ctrl : (!w && a == 8'h04) ? m_cfg : 32'h0;
    apb(w, a, d);
    chk("pslverr", {31'h0, a > 8'h08 || a[1:0] != 2'h0}, {31'h0, erv});
    if (a != 8'h08) chk("prdata", e, rdv);
    if (w && a == 8'h00) m_ctrl = d & 32'hFF;
    if (w && a == 8'h04) m_err = d[1] && d[2];
    if (w && a == 8'h04 && !m_err) m_cfg = d & 32'hFF;
  endtask

  task automatic stat(input logic [31:0] mask, input logic [31:0] e);
    acc(1'b0, 8'h08, 32'h0);
    chk("status", (e | {24'h0, m_err, 7'h0}) & mask, rdv & mask);
  endtask

  // after settling, output must copy the chosen source two cycles late
  task automatic follow(input int s, input logic idle, input int n);
    logic [1:0] pa;
    logic [1:0] pb;
    int         k;
    pa = 2'h0;
    pb = 2'h0;
    repeat (n) @(posedge pclk);
    for (k = 0; k < 42; k++) begin
      @(posedge pclk);
      #1;
      if (k > 1)
        chk("clock_out", {31'h0, s == 1 ? pa[1] : s == 2 ? pb[1] : idle},
            {31'h0, clock_out});
      pa = {pa[0], clock_in_a};
      pb = {pb[0], clock_in_b};
    end
  endtask

  // wait for a source to be high, then freeze it there
  task automatic stop_hi(input logic b);
    int k;
    for (k = 0; k < 40; k++) begin
      @(posedge pclk);
      #1;
      if ((b ? clock_in_b : clock_in_a) === 1'b1) break;
    end
    if (k == 40) give_up();
    if (b) run_b <= 1'b0;
    else run_a <= 1'b0;
  endtask

  // a pulse shorter than either source's half period is a glitch
  always @(posedge pclk) begin
    if (clock_out !== last_out) begin
      if (watch) chk("pulse_ok", 32'h1, {31'h0, run_len >= half_a});
      run_len = 0;
    end
    run_len++;
    last_out = clock_out;
  end

  initial begin
    seed = 32'hECF31B29;
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    half_a = 4'h3 + 4'($random(seed) & 3);
    half_b = half_a + 4'h1 + 4'($random(seed) & 1);
    run_a = 1'b1;
    run_b = 1'b1;
    {m_ctrl, m_cfg, m_err, watch, last_out} = '0;
    {errors, n_tests, run_len} = '0;
    settle = 6 * half_b + 4;
    // cfg, ctrl, source, idle of each fixed configuration except the dual switch
    vt = '{32'h10020101, 32'h10000001, 32'h20800200, 32'h30000100,
           32'h40800200, 32'h50800200, 32'h28800200, 32'h60820200,
           32'h60800000, 32'h70020100, 32'h70000000, 32'h70400100,
           32'h78020100, 32'h80000100};
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    acc(1'b0, 8'h00, 32'h0);
    acc(1'b0, 8'h04, 32'h0);
    stat(32'h93, 32'h0);
    acc(1'b1, 8'h0C, $random(seed));
    acc(1'b0, 8'hFC, 32'h0);
    acc(1'b1, 8'h00, $random(seed));
    acc(1'b0, 8'h00, 32'h0);
    acc(1'b1, 8'h04, 32'h06);
    stat(32'h80, 32'h0);
    acc(1'b0, 8'h04, 32'h0);
    acc(1'b1, 8'h04, 32'h0);
    stat(32'h80, 32'h0);
    acc(1'b1, 8'h00, 32'h03);
    follow(1, 1'b0, 100);
    watch = 1'b1;
    acc(1'b1, 8'h00, 32'h0C);
    follow(2, 1'b0, 100);
    acc(1'b1, 8'h00, 32'h0F);
    follow(2, 1'b0, 100);
    acc(1'b1, 8'h00, 32'h05);
    follow(0, 1'b0, 100);
    watch = 1'b0;
    acc(1'b1, 8'h04, 32'h01);
    follow(0, 1'b1, 100);
    acc(1'b1, 8'h00, 32'h03);
    follow(1, 1'b1, 100);
    acc(1'b1, 8'h00, 32'h0C);
    acc(1'b1, 8'h04, 32'h02);
    stat(32'h03, 32'h01);
    acc(1'b1, 8'h04, 32'h04);
    stat(32'h03, 32'h02);
    foreach (vt[i]) begin
      acc(1'b1, 8'h04, {24'h0, vt[i][31:24]});
      acc(1'b1, 8'h00, {24'h0, vt[i][23:16]});
      follow(vt[i][15:8], vt[i][0], settle);
    end
    acc(1'b1, 8'h04, 32'h0);
    acc(1'b1, 8'h00, 32'h2C);
    follow(2, 1'b0, 100);
    stop_hi(1'b1);
    acc(1'b1, 8'h00, 32'h23);
    follow(1, 1'b0, 100);
    run_b <= 1'b1;
    acc(1'b1, 8'h00, 32'h07);
    follow(1, 1'b0, 100);
    stop_hi(1'b0);
    acc(1'b1, 8'h00, 32'h0D);
    follow(1, 1'b0, 4);
    run_a <= 1'b1;
    acc(1'b1, 8'h00, 32'h0D);
    follow(2, 1'b0, 100);
    print_verdict();
  end
endmodule
`default_nettype wire
